// ---- trsb_pkg.sv ----
// constants for the token ring serial station: register indices, flag bit
// positions, ring state numbers and the serial clock divider.
// assumes a 10 MHz mclk and a shared ring clock of 800 ns period.
//
// Overview of operation
// RULE_01: idle state: requesters pull data low, clock resumes
// RULE_02: entering state 1, last master keeps previous-owner flag
// RULE_03: token out high: previous owner, or passing token
// RULE_04: new master releases data high during state 1
// RULE_05: state 2 stops clock; master sets interrupt flag
// RULE_06: processor reads pending message, then loads bytes
// RULE_07: low message byte write clears write pending
// RULE_08: master pulls data low; half cycle later state 3
// RULE_09: read pending before state 3 makes station deaf
// RULE_10: master drives message bits in states 3-34
// RULE_11: non-deaf stations shift message in states 3-34
// RULE_12: transmit on clock rise, sample on clock fall
// RULE_13: master releases data high during state 35
// RULE_14: addressed non-deaf station acknowledges in state 36
// RULE_15: master samples acknowledge; high sets not-acknowledged
// RULE_16: addressed non-deaf station sets read pending, state 37
// RULE_17: data high in state 37, then back to 0
// RULE_18: top byte read clears read pending
// RULE_19: readable state value is one-hot, seven bits
// RULE_20: station address compared with top three message bits
// RULE_21: begin low time from load until first bit
// RULE_22: interrupt is enable and master, nak or pending
// RULE_23: writing one clears interrupt flag; zero ignored
// RULE_24: counter 0 to 37 wraps, reset to 0
// RULE_25: clock source enable makes station drive ring clock
// RULE_26: data line is wired-AND, released or pulled low
package trsb_pkg;

    localparam int MCLK_PERIOD_NS = 100;
    localparam int RING_CLK_PERIOD_NS = 800;
    localparam int HALF_DIV_INT = (RING_CLK_PERIOD_NS + 2 * MCLK_PERIOD_NS - 1) / (2 * MCLK_PERIOD_NS);
    localparam logic [2:0] RING_HALF_DIV = 3'(HALF_DIV_INT);

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int BYTE_W = 8;
    localparam int IDX_W = 6;
    localparam int STATE_W = 6;
    localparam int MSG_W = 32;
    localparam int MSG_BYTES = 4;
    localparam int ONEHOT_W = 7;
    localparam int STATION_W = 3;
    localparam int SYNC_W = 3;

    // register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_STATE = 6'h14;
    localparam logic [IDX_W-1:0] IDX_MSG_LOW = 6'h15;
    localparam logic [IDX_W-1:0] IDX_MSG_TOP = 6'h18;
    localparam logic [IDX_W-1:0] IDX_SCSR = 6'h19;
    localparam logic [IDX_W-1:0] IDX_BAR = 6'h1a;
    localparam logic [IDX_W-1:0] IDX_CTRL = 6'h1b;

    // control and status bit positions
    localparam int WP_BIT = 0;
    localparam int MASTER_BIT = 1;
    localparam int PREV_BIT = 2;
    localparam int NAK_BIT = 3;
    localparam int RP_BIT = 4;
    localparam int DEAF_BIT = 5;
    localparam int CLKSRC_BIT = 6;
    localparam int IRQ_BIT = 7;
    localparam int BLOCK_EN_BIT = 2;

    // ring states
    localparam logic [STATE_W-1:0] ST_IDLE = 6'd0;
    localparam logic [STATE_W-1:0] ST_ARB = 6'd1;
    localparam logic [STATE_W-1:0] ST_LOAD = 6'd2;
    localparam logic [STATE_W-1:0] ST_FIRST_BIT = 6'd3;
    localparam logic [STATE_W-1:0] ST_LAST_BIT = 6'd34;
    localparam logic [STATE_W-1:0] ST_END = 6'd35;
    localparam logic [STATE_W-1:0] ST_ACK = 6'd36;
    localparam logic [STATE_W-1:0] ST_DONE = 6'd37;

    // one-hot positions of the readable state value
    localparam int OH_SHIFT = 3;
    localparam int OH_END = 4;
    localparam int OH_ACK = 5;
    localparam int OH_DONE = 6;

    localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
    localparam logic [STATION_W-1:0] BAR_RESET = 3'h0;
    localparam logic [MSG_W-1:0] MSG_RESET = 32'h0000_0000;

endpackage

// ---- trsb_ring_station.sv ----
// one station of the token ring serial bus with its avalon-mm register slave.
// assumes a push-pull ring clock and an open-drain data wire with pull-ups resolved outside,
// and a daisy-chained token from the upstream station.
//
// Decided for this implementation: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps

module trsb_ring_station (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [trsb_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [trsb_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [trsb_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic ring_clk_in,
    output logic ring_clk_out,
    output logic ring_clk_oe,
    input wire logic ring_data_line_in,
    output logic ring_data_line_out,
    output logic ring_data_line_oe,
    input wire logic token_input,
    output logic token_output,
    output logic ring_interrupt
);
    import trsb_pkg::*;

    logic [SYNC_W-1:0] sync_a;
    logic [SYNC_W-1:0] sync_b;
    logic clk_s;
    logic dat_s;
    logic tok_s;
    logic clk_q;
    logic clk_rise;
    logic clk_fall;

    logic [STATE_W-1:0] st;
    logic [STATE_W-1:0] next_st;
    logic in_shift;
    logic ent_arb;
    logic ent_load;
    logic ent_first;
    logic ent_done;
    logic tx_load;

    logic write_pending_flag;
    logic master_flag;
    logic previous_owner_flag;
    logic not_acknowledged_flag;
    logic read_pending_flag;
    logic deaf_flag;
    logic local_clock_source_enable;
    logic ring_interrupt_flag;
    logic ring_block_enable;
    logic sender;
    logic msg_seen;
    logic tx_bit;
    logic [STATION_W-1:0] station_addr;
    logic [MSG_W-1:0] msg;
    logic addr_match;
    logic next_dat_oe;
    logic [2:0] div;
    logic clk_hold;

    logic [IDX_W-1:0] idx;
    logic aligned;
    logic rd_go;
    logic wr_go;
    logic wr_scsr;
    logic [BYTE_W-1:0] wbyte;
    logic [BYTE_W-1:0] rd_mux;
    logic [BYTE_W-1:0] scsr_v;

    function automatic logic [ONEHOT_W-1:0] state_onehot(input logic [STATE_W-1:0] s);
        logic [ONEHOT_W-1:0] v;
        v = '0;
        if (s <= ST_LOAD) begin
            v[s[2:0]] = 1'b1;
        end else if (s <= ST_LAST_BIT) begin
            v[OH_SHIFT] = 1'b1;
        end else if (s == ST_END) begin
            v[OH_END] = 1'b1;
        end else if (s == ST_ACK) begin
            v[OH_ACK] = 1'b1;
        end else begin
            v[OH_DONE] = 1'b1;
        end
        return v;
    endfunction

    // pin synchronisers: clock, data and token
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            sync_a <= '1;
            sync_b <= '1;
            clk_q <= 1'b1;
        end else begin
            sync_a <= {token_input, ring_data_line_in, ring_clk_in};
            sync_b <= sync_a;
            clk_q <= sync_b[0];
        end
    end

    assign clk_s = sync_b[0];
    assign dat_s = sync_b[1];
    assign tok_s = sync_b[2];
    assign clk_rise = clk_s && !clk_q;
    assign clk_fall = !clk_s && clk_q;

    // ring state counter, same in every station
    assign next_st = (st == ST_DONE) ? ST_IDLE : STATE_W'(st + 6'd1);

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            st <= ST_IDLE;
        end else if (clk_rise) begin
            st <= next_st; // [RULE_24] [RULE_17]
        end
    end

    assign in_shift = (st >= ST_FIRST_BIT) && (st <= ST_LAST_BIT);
    assign ent_arb = clk_rise && (st == ST_IDLE);
    assign ent_load = clk_rise && (st == ST_ARB);
    assign ent_first = clk_rise && (st == ST_LOAD);
    assign ent_done = clk_rise && (st == ST_ACK);
    assign tx_load = clk_rise && (st >= ST_LOAD) && (st < ST_LAST_BIT);

    // top three message bits carry the destination station
    assign addr_match = !deaf_flag && (msg[MSG_W-1 -: STATION_W] == station_addr); // [RULE_20]

    // register bus decode
    assign idx = avs_address[ADDR_W-1:2];
    assign aligned = (avs_address[1:0] == 2'b00);
    assign rd_go = avs_read && !avs_waitrequest && aligned;
    assign wr_go = avs_write && !avs_waitrequest && aligned && avs_byteenable[0];
    assign wr_scsr = wr_go && (idx == IDX_SCSR);
    assign wbyte = avs_writedata[BYTE_W-1:0];

    // one wait cycle, then the request is taken
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
        end
    end

    always_comb begin
        scsr_v = BYTE_ZERO;
        scsr_v[WP_BIT] = write_pending_flag;
        scsr_v[MASTER_BIT] = master_flag;
        scsr_v[PREV_BIT] = previous_owner_flag;
        scsr_v[NAK_BIT] = not_acknowledged_flag;
        scsr_v[RP_BIT] = read_pending_flag;
        scsr_v[DEAF_BIT] = deaf_flag;
        scsr_v[CLKSRC_BIT] = local_clock_source_enable;
        scsr_v[IRQ_BIT] = ring_interrupt_flag;
    end

    always_comb begin
        rd_mux = BYTE_ZERO;
        if (aligned) begin
            if (idx == IDX_STATE) begin
                rd_mux = {1'b0, state_onehot(st)}; // [RULE_19]
            end else if (idx >= IDX_MSG_LOW && idx <= IDX_MSG_TOP) begin
                rd_mux = msg[BYTE_W * 32'(idx - IDX_MSG_LOW) +: BYTE_W];
            end else if (idx == IDX_SCSR) begin
                rd_mux = scsr_v;
            end else if (idx == IDX_BAR) begin
                rd_mux = {5'h00, station_addr};
            end else if (idx == IDX_CTRL) begin
                rd_mux[BLOCK_EN_BIT] = ring_block_enable;
            end
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            avs_readdata <= '0;
        end else if (avs_read && avs_waitrequest) begin
            avs_readdata <= {24'h000000, rd_mux};
        end
    end

    // message shift register and processor byte access
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            msg <= MSG_RESET;
        end else if (clk_fall && in_shift && !deaf_flag) begin
            msg <= {msg[MSG_W-2:0], dat_s}; // [RULE_11] [RULE_12]
        end else begin
            for (int i = 0; i < MSG_BYTES; i++) begin
                if (wr_go && idx == IDX_W'(IDX_MSG_LOW + i)) begin
                    msg[BYTE_W*i +: BYTE_W] <= wbyte;
                end
            end
        end
    end

    // transmit bit changes only on ring clock rise
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            tx_bit <= 1'b1;
        end else if (tx_load) begin
            tx_bit <= msg[MSG_W-1]; // [RULE_12]
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            write_pending_flag <= 1'b0;
        end else if (wr_scsr && wbyte[WP_BIT]) begin
            write_pending_flag <= 1'b1;
        end else if (wr_go && idx == IDX_MSG_LOW) begin
            write_pending_flag <= 1'b0; // [RULE_07]
        end
    end

    // mastery is granted on entry to state 2, handed to sender at state 3
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            master_flag <= 1'b0;
        end else if (ent_load) begin
            master_flag <= tok_s && write_pending_flag; // [RULE_03]
        end else if (ent_first) begin
            master_flag <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            sender <= 1'b0;
            msg_seen <= 1'b0;
        end else if (ent_first) begin
            sender <= master_flag;
            msg_seen <= 1'b1;
        end
    end

    // software seeds one owner; after a message the last sender keeps it
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            previous_owner_flag <= 1'b0;
        end else if (wr_scsr && wbyte[PREV_BIT]) begin
            previous_owner_flag <= 1'b1;
        end else if (ent_arb && msg_seen) begin
            previous_owner_flag <= sender; // [RULE_02]
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            token_output <= 1'b0;
        end else begin
            token_output <= previous_owner_flag || (tok_s && !write_pending_flag); // [RULE_03]
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            deaf_flag <= 1'b0;
        end else if (ent_first) begin
            deaf_flag <= read_pending_flag; // [RULE_09]
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            not_acknowledged_flag <= 1'b0;
        end else if (ent_done && sender) begin
            not_acknowledged_flag <= dat_s; // [RULE_15]
        end
    end

    // new message beats a same-cycle clear by a top byte read
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            read_pending_flag <= 1'b0;
        end else if (ent_done && addr_match) begin
            read_pending_flag <= 1'b1; // [RULE_16]
        end else if (rd_go && idx == IDX_MSG_TOP) begin
            read_pending_flag <= 1'b0; // [RULE_18]
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ring_interrupt_flag <= 1'b0;
        end else if (ent_load && tok_s && write_pending_flag) begin
            ring_interrupt_flag <= 1'b1; // [RULE_05]
        end else if (ent_done && ((sender && dat_s) || addr_match)) begin
            ring_interrupt_flag <= 1'b1; // [RULE_15] [RULE_16]
        end else if (wr_scsr && wbyte[IRQ_BIT]) begin
            ring_interrupt_flag <= 1'b0; // [RULE_23]
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            local_clock_source_enable <= 1'b0;
        end else if (wr_scsr && wbyte[CLKSRC_BIT]) begin
            local_clock_source_enable <= 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            station_addr <= BAR_RESET;
            ring_block_enable <= 1'b0;
        end else if (wr_go && idx == IDX_BAR) begin
            station_addr <= wbyte[STATION_W-1:0];
        end else if (wr_go && idx == IDX_CTRL) begin
            ring_block_enable <= wbyte[BLOCK_EN_BIT];
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ring_interrupt <= 1'b0;
        end else begin
            ring_interrupt <= ring_block_enable &&
                (master_flag || not_acknowledged_flag || read_pending_flag); // [RULE_22]
        end
    end

    // data pin: enable pulls low, released level is the pull-up
    always_comb begin
        next_dat_oe = 1'b0; // [RULE_26] [RULE_04] [RULE_13] [RULE_17]
        if (st == ST_IDLE) begin
            next_dat_oe = write_pending_flag; // [RULE_01]
        end else if (tx_load) begin
            // next bit leaves as soon as the rise is seen, so it has settled before the fall
            next_dat_oe = ((st == ST_LOAD) ? master_flag : sender) && !msg[MSG_W-1]; // [RULE_10] [RULE_12]
        end else if (st == ST_LOAD) begin
            next_dat_oe = master_flag && !write_pending_flag; // [RULE_08] [RULE_21]
        end else if (in_shift) begin
            next_dat_oe = sender && !tx_bit; // [RULE_10]
        end else if (st == ST_ACK) begin
            next_dat_oe = addr_match; // [RULE_14]
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ring_data_line_oe <= 1'b0;
            ring_data_line_out <= 1'b0;
        end else begin
            ring_data_line_oe <= next_dat_oe;
            ring_data_line_out <= 1'b0;
        end
    end

    // ring clock generator: holds low in states 0 and 2 while data is high
    assign clk_hold = ((st == ST_IDLE) || (st == ST_LOAD)) && dat_s; // [RULE_01] [RULE_05]

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            div <= 3'h0;
            ring_clk_out <= 1'b0;
        end else if (!local_clock_source_enable) begin
            div <= 3'h0;
            ring_clk_out <= 1'b0;
        end else if (!ring_clk_out && clk_hold) begin
            div <= 3'h0; // [RULE_08]
        end else if (div == 3'(RING_HALF_DIV - 3'h1)) begin
            div <= 3'h0;
            ring_clk_out <= !ring_clk_out; // [RULE_25]
        end else begin
            div <= 3'(div + 3'h1);
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ring_clk_oe <= 1'b0;
        end else begin
            ring_clk_oe <= local_clock_source_enable; // [RULE_25]
        end
    end

endmodule

// ---- trsb_ring_station_monitor.sv ----
// checker for one ring station: bus handshake, ring clock shape, data pin use.
// assumes a ring clock half period of four mclk cycles.
`timescale 1ns/1ps

module trsb_ring_station_monitor (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [trsb_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [trsb_pkg::DATA_W-1:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic ring_clk_out,
    input wire logic ring_clk_oe,
    input wire logic ring_data_line_out,
    input wire logic ring_data_line_oe
);
    import trsb_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);

    a_data_pull_only: assert property (ring_data_line_oe |-> !ring_data_line_out)
        else $error("data line driven high");
    a_clk_high_len: assert property ($rose(ring_clk_out) |-> ring_clk_out [*4] ##1 !ring_clk_out)
        else $error("ring clock high phase wrong");
    a_clk_low_min: assert property ($fell(ring_clk_out) |-> !ring_clk_out [*4])
        else $error("ring clock low phase short");
    a_clk_src_sticky: assert property ($past(ring_clk_oe) |-> ring_clk_oe)
        else $error("clock source dropped");
    a_wait_answer: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
        else $error("no answer one cycle after request");
    a_wait_pulse: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
        else $error("waitrequest low too long");
    a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address[1:0] != 2'b00
        |-> avs_readdata == 32'h0000_0000)
        else $error("unaligned read not zero");
    a_state_onehot: assert property (avs_read && !avs_waitrequest && avs_address == {IDX_STATE, 2'b00}
        |-> $onehot(avs_readdata[6:0]) && avs_readdata[31:7] == 25'h0)
        else $error("state value not one-hot");
    a_read_upper_zero: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h00_0000)
        else $error("read data upper bits set");
endmodule

bind trsb_ring_station trsb_ring_station_monitor u_mon (
    .mclk(mclk),
    .reset(reset),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .ring_clk_out(ring_clk_out),
    .ring_clk_oe(ring_clk_oe),
    .ring_data_line_out(ring_data_line_out),
    .ring_data_line_oe(ring_data_line_oe)
);

// ---- trsb_ring_peer.sv ----
// behavioural model of a downstream ring station that never requests mastery.
// assumes resolved ring clock and data wires with pull-ups.
`timescale 1ns/1ps

module trsb_ring_peer #(
    parameter logic [2:0] STATION = 3'h5
) (
    input wire logic reset,
    input wire logic ring_clk,
    input wire logic ring_data,
    input wire logic token_in,
    output logic token_out,
    output logic data_pull,
    output logic [31:0] rx_msg
);
    logic [5:0] state;

    always_ff @(posedge ring_clk or posedge reset) begin
        if (reset) begin
            state <= 6'h00;
        end else begin
            state <= (state == 6'h25) ? 6'h00 : state + 6'h01;
        end
    end

    // capture on falling edges while the message is on the line
    always_ff @(negedge ring_clk or posedge reset) begin
        if (reset) begin
            rx_msg <= 32'h0000_0000;
        end else if (state >= 6'h03 && state <= 6'h22) begin
            rx_msg <= {rx_msg[30:0], ring_data};
        end
    end

    // ack pulls from the fall in state 36 to the fall in state 37, across the sampling rise
    always_ff @(negedge ring_clk or posedge reset) begin
        if (reset) begin
            data_pull <= 1'b0;
        end else begin
            data_pull <= (state == 6'h24) && (rx_msg[31:29] == STATION);
        end
    end
    assign token_out = token_in;
endmodule

// ---- trsb_ring_station_tb.sv ----
// self-checking bench: one station as ring clock source facing a listening peer.
// assumes the station's avalon-mm slave answers with one waitrequest-low cycle.
`timescale 1ns/1ps

module trsb_ring_station_tb;
    import trsb_pkg::*;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic [ADDR_W-1:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [DATA_W-1:0] avs_writedata = 32'h0000_0000;
    logic [3:0] avs_byteenable = 4'hf;
    logic [DATA_W-1:0] avs_readdata;
    logic avs_waitrequest, ring_clk_out, ring_clk_oe, data_out, data_oe, token_out, token_in, ring_interrupt;
    logic peer_pull;
    logic [MSG_W-1:0] peer_msg;
    logic [7:0] rd_val;
    int n_fail = 0;
    int checked = 0;
    // address and expected read value after reset
    logic [15:0] rows [7] = '{16'h5001, 16'h6400, 16'h6800, 16'h6c00, 16'h5400, 16'h0000, 16'h5100};
    wire ring_clk = ring_clk_oe ? ring_clk_out : 1'b1;
    wire ring_data = !((data_oe && !data_out) || peer_pull);

    always #50 mclk = ~mclk;

    trsb_ring_station DUT (
        .mclk(mclk),
        .reset(reset),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .ring_clk_in(ring_clk),
        .ring_clk_out(ring_clk_out),
        .ring_clk_oe(ring_clk_oe),
        .ring_data_line_in(ring_data),
        .ring_data_line_out(data_out),
        .ring_data_line_oe(data_oe),
        .token_input(token_in),
        .token_output(token_out),
        .ring_interrupt(ring_interrupt)
    );

    trsb_ring_peer #(.STATION(3'h5)) u_peer (
        .reset(reset),
        .ring_clk(ring_clk),
        .ring_data(ring_data),
        .token_in(token_out),
        .token_out(token_in),
        .data_pull(peer_pull),
        .rx_msg(peer_msg)
    );

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] addr, input logic [7:0] data);
        int i;
        @(posedge mclk);
        avs_address <= addr;
        avs_writedata <= {24'h00_0000, data};
        avs_read <= !wr;
        avs_write <= wr;
        for (i = 0; i < 20; i++) begin
            @(posedge mclk);
            if (avs_waitrequest === 1'b0) break;
        end
        if (i == 20) begin
            n_fail++;
            $display("Error %0t: bus access timed out", $time);
            end_sim();
        end
        rd_val = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wait_state(input logic [7:0] exp);
        int i;
        for (i = 0; i < 400; i++) begin
            bus(1'b0, 8'h50, 8'h00);
            if (rd_val === exp) break;
        end
        chk(rd_val, exp);
        if (i == 400) end_sim();
    endtask

    task automatic reset_table();
        int r;
        chk({avs_waitrequest, ring_interrupt}, 2'b10);
        for (r = 0; r < 7; r++) begin
            bus(1'b0, rows[r][15:8], 8'h00);
            chk(rd_val, rows[r][7:0]);
        end
    endtask

    // request the ring, load the message low byte last, wait for the frame end
    task automatic send(input logic [31:0] msg, input logic [7:0] exp_scsr);
        int k;
        bus(1'b1, 8'h64, 8'h01);
        wait_state(8'h04);
        bus(1'b0, 8'h64, 8'h00);
        chk(rd_val & 8'h83, 8'h83);
        chk({token_out, ring_interrupt}, 2'b11);
        for (k = 3; k >= 0; k--) begin
            bus(1'b1, 8'h54 + 8'(4 * k), msg[8 * k +: 8]);
        end
        wait_state(8'h01);
        bus(1'b0, 8'h64, 8'h00);
        chk(rd_val, exp_scsr);
    endtask

    initial begin
        repeat (4) @(posedge mclk);
        reset <= 1'b0;
        reset_table();
        bus(1'b1, 8'h6c, 8'h04);
        bus(1'b1, 8'h68, 8'h02);
        bus(1'b1, 8'h64, 8'h44);
        bus(1'b0, 8'h64, 8'h00);
        chk(rd_val, 8'h44);
        send(32'hb4c3_d2e1, 8'hc4);
        chk(peer_msg, 32'hb4c3_d2e1);
        chk(ring_interrupt, 1'b0);
        bus(1'b0, 8'h54, 8'h00);
        chk(rd_val, 8'he1);
        bus(1'b1, 8'h64, 8'h80);
        bus(1'b0, 8'h64, 8'h00);
        chk(rd_val, 8'h44);
        send(32'h6a5f_0c93, 8'hcc);
        chk(ring_interrupt, 1'b1);
        bus(1'b1, 8'h6c, 8'h00);
        repeat (2) @(posedge mclk);
        chk(ring_interrupt, 1'b0);
        bus(1'b1, 8'h6c, 8'h04);
        bus(1'b1, 8'h64, 8'h80);
        send(32'h4e21_7b38, 8'hd4);
        chk(peer_msg, 32'h4e21_7b38);
        send(32'h4111_2233, 8'hfc);
        bus(1'b0, 8'h60, 8'h00);
        chk(rd_val, 8'h41);
        bus(1'b0, 8'h64, 8'h00);
        chk(rd_val, 8'hec);
        reset <= 1'b1;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        reset_table();
        end_sim();
    end
endmodule
